//--- inc/alu_ops_pkg.sv
// Shared constants and types for the subtract/xor/swap datapath
package alu_ops_pkg;
  localparam int DataWidth = 8;
  localparam int RegAddrWidth = 7;
  localparam logic [6:0] RegAddrMax = 7'h7f;
  localparam int NibbleLo = 0;
  localparam int NibbleHi = 4;
  localparam logic [7:0] AccReset = 8'h00;
  localparam logic CarryReset = 1'b0;
  localparam logic NibbleBorrowReset = 1'b0;
  localparam logic ZeroReset = 1'b0;
  localparam logic DestAcc = 1'b0;
  localparam logic DestReg = 1'b1;

  typedef enum logic [1:0] {
    OpSubAccFromReg = 2'h0,
    OpXorAccWithReg = 2'h1,
    OpNibbleExchange = 2'h3,
    OpXorAccWithImm = 2'h2
  } alu_op_t;
endpackage

//--- core/alu_result_unit.sv
// Combinational result and flag generation for the four operations
`timescale 1ns/1ps
module alu_result_unit
  import alu_ops_pkg::*;
(
  input wire alu_op_t op,
  input wire logic [7:0] accVal,
  input wire logic [7:0] regVal,
  input wire logic [7:0] immVal,
  output logic [7:0] result,
  output logic carryOut,
  output logic nibbleBorrowOut,
  output logic zeroOut,
  output logic carryWe,
  output logic nibbleBorrowWe,
  output logic zeroWe
);
  // Ninth bit of reg + ~acc + 1 is the no-borrow carry
  function automatic logic [8:0] subNoBorrow(input logic [7:0] a,
                                             input logic [7:0] b);
    subNoBorrow = {1'b0, a} + {1'b0, ~b} + 9'h001;
  endfunction

  logic [8:0] diff;
  logic [4:0] nibDiff;

  always_comb begin
    diff = subNoBorrow(regVal, accVal);
    nibDiff = {1'b0, regVal[3:0]} + {1'b0, ~accVal[3:0]} + 5'h01;
    result = 8'h00;
    carryOut = 1'b0;
    nibbleBorrowOut = 1'b0;
    carryWe = 1'b0;
    nibbleBorrowWe = 1'b0;
    zeroWe = 1'b0;
    unique case (op)
      OpSubAccFromReg: begin
        result = diff[7:0];
        carryOut = diff[8];
        nibbleBorrowOut = nibDiff[4];
        carryWe = 1'b1;
        nibbleBorrowWe = 1'b1;
        zeroWe = 1'b1;
      end
      OpXorAccWithReg: begin
        result = accVal ^ regVal;
        zeroWe = 1'b1;
      end
      OpNibbleExchange: begin
        // Flags untouched by design
        result = {regVal[NibbleHi-1:NibbleLo],
                  regVal[DataWidth-1:NibbleHi]};
      end
      OpXorAccWithImm: begin
        result = accVal ^ immVal;
        zeroWe = 1'b1;
      end
    endcase
    zeroOut = (result == 8'h00);
  end
endmodule

//--- core/alu_sub_xor_swap_ops.sv
// Execution stage for subtract, xor, xor-immediate and nibble swap
// How it works
// - Register form takes a 7-bit address 0..127 and a one-bit destination.
// - Destination bit 0 writes the accumulator, 1 writes the register back.
// - Subtract computes register minus accumulator in two's complement.
// - Subtract updates carry, nibble borrow, zero; carry clear when acc > reg.
// - Nibble borrow clear when acc low nibble exceeds register low nibble.
// - Register xor goes to selected destination, updates zero flag only.
// - Nibble swap exchanges halves, honours destination, flags unchanged.
// - Immediate xor always writes accumulator, updates zero flag only.
`timescale 1ns/1ps
module alu_sub_xor_swap_ops
  import alu_ops_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic opValid,
  input wire alu_op_t opCode,
  input wire logic [RegAddrWidth-1:0] regAddr,
  input wire logic resultTargetSelect,
  input wire logic [7:0] immValue,
  input wire logic [7:0] regReadData,
  output logic [RegAddrWidth-1:0] regReadAddr,
  output logic regWriteEn,
  output logic [RegAddrWidth-1:0] regWriteAddr,
  output logic [7:0] regWriteData,
  output logic [7:0] accValue,
  output logic carryFlag,
  output logic nibbleBorrowFlag,
  output logic zeroFlag
);
  typedef struct packed {
    logic [7:0] acc;
    logic carry;
    logic nibbleBorrow;
    logic zero;
    logic wrEn;
    logic [6:0] wrAddr;
    logic [7:0] wrData;
  } state_t;

  state_t q, d;
  logic [7:0] aluRes;
  logic cOut, nbOut, zOut, cWe, nbWe, zWe;
  logic toReg;

  initial begin
    if (RegAddrWidth != 7 || DataWidth != 8)
      $error("alu_sub_xor_swap_ops supports 7-bit address, 8-bit data");
  end

  // Register file read is combinational on the same clock
  assign regReadAddr = regAddr;

  alu_result_unit u_result (
    .op(opCode),
    .accVal(q.acc),
    .regVal(regReadData),
    .immVal(immValue),
    .result(aluRes),
    .carryOut(cOut),
    .nibbleBorrowOut(nbOut),
    .zeroOut(zOut),
    .carryWe(cWe),
    .nibbleBorrowWe(nbWe),
    .zeroWe(zWe)
  );

  always_comb begin
    d = q;
    d.wrEn = 1'b0;
    // Immediate form has no register target, destination bit ignored
    toReg = (resultTargetSelect == DestReg) &&
            (opCode != OpXorAccWithImm);
    if (opValid) begin
      if (toReg) begin
        d.wrEn = 1'b1;
        d.wrAddr = regAddr;
        d.wrData = aluRes;
      end else begin
        d.acc = aluRes;
      end
      if (cWe)
        d.carry = cOut;
      if (nbWe)
        d.nibbleBorrow = nbOut;
      if (zWe)
        d.zero = zOut;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '{acc: AccReset, carry: CarryReset,
             nibbleBorrow: NibbleBorrowReset, zero: ZeroReset,
             wrEn: 1'b0, wrAddr: 7'h00, wrData: 8'h00};
    end else begin
      q <= d;
    end
  end

  assign regWriteEn = q.wrEn;
  assign regWriteAddr = q.wrAddr;
  assign regWriteData = q.wrData;
  assign accValue = q.acc;
  assign carryFlag = q.carry;
  assign nibbleBorrowFlag = q.nibbleBorrow;
  assign zeroFlag = q.zero;
endmodule

//--- testbench/alu_sub_xor_swap_ops_assertions.sv
// Checker for the subtract/xor/swap datapath
`timescale 1ns/1ps
module alu_chk
  import alu_ops_pkg::*;
(
  input wire logic sys_clk, rst_b, opValid, resultTargetSelect,
  input wire alu_op_t opCode,
  input wire logic [6:0] regAddr, regReadAddr, regWriteAddr,
  input wire logic [7:0] regReadData, regWriteData, accValue,
  input wire logic regWriteEn, carryFlag, nibbleBorrowFlag, zeroFlag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  logic w;
  // Register write-back request: immediate xor never writes back
  assign w = opValid && resultTargetSelect && opCode != 2'h2;
  a_read_addr: assert property (regReadAddr == regAddr)
    else $error("read address");
  a_sub_acc: assert property (opValid && opCode == 2'h0 && !w |=>
    accValue == $past(regReadData) - $past(accValue)) else $error("sub");
  a_sub_carry: assert property (opValid && opCode == 2'h0 |=>
    carryFlag == ($past(accValue) <= $past(regReadData))) else $error("c");
  a_sub_nibble: assert property (opValid && opCode == 2'h0 |=>
    nibbleBorrowFlag == ($past(accValue[3:0]) <= $past(regReadData[3:0])))
    else $error("nibble");
  a_write_back: assert property (w |=>
    regWriteEn && regWriteAddr == $past(regAddr)) else $error("write");
  a_no_write: assert property (!w |=> !regWriteEn)
    else $error("stray write");
  a_swap_data: assert property (w && opCode == 2'h3 |=>
    regWriteData == {$past(regReadData[3:0]), $past(regReadData[7:4])})
    else $error("swap");
  a_swap_flags: assert property (opValid && opCode == 2'h3 |=>
    $stable({carryFlag, nibbleBorrowFlag, zeroFlag})) else $error("flags");
  a_xor_carry: assert property (opValid && ^opCode |=>
    $stable({carryFlag, nibbleBorrowFlag})) else $error("xor flags");
  a_imm_zero: assert property (opValid && opCode == 2'h2 |=>
    zeroFlag == (accValue == 8'h00)) else $error("zero");
  cover property (w ##1 w);
  cover property (opValid && opCode == 2'h2 ##1 zeroFlag);
  cover property (opValid && opCode == 2'h0 ##1 !carryFlag);
endmodule
bind alu_sub_xor_swap_ops alu_chk chk (.*);

//--- testbench/alu_sub_xor_swap_ops_tb_top.sv
// Self-checking bench for the subtract/xor/swap datapath
`timescale 1ns/1ps
module alu_sub_xor_swap_ops_tb_top
  import alu_ops_pkg::*;
;
  logic sys_clk = 1'h0, rst_b = 1'h0, opValid = 1'h0, resultTargetSelect;
  alu_op_t opCode;
  logic [6:0] regAddr, regReadAddr, regWriteAddr, wA;
  logic [7:0] immValue, regReadData, regWriteData, accValue, wD, eA = 8'h00;
  logic regWriteEn, carryFlag, nibbleBorrowFlag, zeroFlag, wE = 1'h0;
  logic eC = 1'h0, eN = 1'h0, eZ = 1'h0;
  logic [7:0] rf [128];
  int mismatches = 0, total_checks = 0, seed = 46;
  always #5 sys_clk = ~sys_clk;
  // The bench is the register file; writes land before the next read
  assign regReadData = rf[regReadAddr];
  alu_sub_xor_swap_ops DUT (.*);
  task automatic chk(logic [7:0] g, logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  function automatic logic [10:0] calc(logic [1:0] o, logic [7:0] a, r, k);
    logic [7:0] s;
    s = o == 2'h0 ? r - a : o == 2'h1 ? a ^ r : o == 2'h2 ? a ^ k :
      {r[3:0], r[7:4]};
    return {a <= r, a[3:0] <= r[3:0], s == 8'h00, s};
  endfunction
  task automatic step(logic v, logic [1:0] o, logic [6:0] d, logic s,
    logic [7:0] k);
    logic [10:0] x;
    chk(accValue, eA);
    chk({5'h00, carryFlag, nibbleBorrowFlag, zeroFlag}, {5'h00, eC, eN, eZ});
    chk({7'h00, regWriteEn}, {7'h00, wE});
    if (wE) begin
      chk(regWriteData, wD);
      chk({1'h0, regWriteAddr}, {1'h0, wA});
      rf[wA] = wD;
    end
    {opValid, regAddr, resultTargetSelect, immValue} = {v, d, s, k};
    opCode = alu_op_t'(o);
    x = calc(o, eA, rf[d], k);
    {wE, wA, wD} = {v && s && o != 2'h2, d, x[7:0]};
    if (v && !wE) eA = x[7:0];
    if (v && o == 2'h0) {eC, eN} = x[10:9];
    if (v && o != 2'h3) eZ = x[8];
    @(negedge sys_clk);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    for (int i = 0; i < 128; i++) rf[i] = 8'($random(seed));
    repeat (20) @(negedge sys_clk);
    rst_b = 1'h1;
    step(1'h1, 2'h2, 7'h00, 1'h0, 8'h01);
    rf[5] = 8'h10;
    step(1'h1, 2'h0, 7'h05, 1'h1, 8'h00);
    for (int o = 0; o < 8; o++) step(1'h1, 2'(o), 7'h7f, 1'(o >> 2), 8'hff);
    rf[9] = eA;
    step(1'h1, 2'h0, 7'h09, 1'h0, 8'h00);
    step(1'h0, 2'h1, 7'h09, 1'h0, 8'h00);
    $display("corner test done");
    repeat (400) step(1'($random(seed)), 2'($random(seed)),
      7'($random(seed)), 1'($random(seed)), 8'($random(seed)));
    $display("random test done");
    print_verdict;
  end
  initial begin
    repeat (2000) @(posedge sys_clk);
    mismatches++;
    print_verdict;
  end
endmodule
